/* File: src/piq_defs.vh */
// Register offsets, field positions and encodings of the port info block
// ===========================================================================
// Functional notes
// RL1: Port 1 bits 7:4 show line type strap
// RL2: Port 1 bits 3:2 show toggle line strap
// RL3: Toggle field meaningless when type is RS232
// RL4: Info bits 1:0 always read zero
// RL5: Port 2 type from its own straps
// RL6: Port 3 type from its own straps
// RL7: Port 4 type from its own straps
// RL8: Ports 2-4 bits 3:2 show toggle line
// RL9: Enable register, one bit per port
// RL10: Pending register, bit per port, 7:4 unused
// RL11: Pending bits active low
// RL12: Interrupt out when enabled port pending
`ifndef PIQ_DEFS_VH
`define PIQ_DEFS_VH
// ===========================================================================
// Offsets in option I/O space
`define PIQ_OFS_INFO1 6'h08
`define PIQ_OFS_INFO2 6'h09
`define PIQ_OFS_INFO3 6'h0a
`define PIQ_OFS_INFO4 6'h0b
`define PIQ_OFS_ENABLE 6'h0c
`define PIQ_OFS_PENDING 6'h10
// ===========================================================================
// Field layout and encodings
`define PIQ_TYPE_HI 7
`define PIQ_TYPE_LO 4
`define PIQ_TGL_HI 3
`define PIQ_TGL_LO 2
`define PIQ_TYPE_RS232 4'h0
`define PIQ_TYPE_RS422 4'h1
`define PIQ_TYPE_RS485 4'h2
`define PIQ_TGL_RTS 2'h0
`define PIQ_TGL_DTR 2'h1
`define PIQ_TGL_TXRX 2'h2
`define PIQ_UNUSED_LOW 2'h0
`define PIQ_ENABLE_RESET 4'h0
`define PIQ_ZERO_HIGH 4'h0
`define PIQ_RDATA_IDLE 8'h00
// ===========================================================================
// Strap pin codes
`define PIQ_STRAP_RS422 2'h1
`define PIQ_STRAP_RS485 2'h2
`define PIQ_STRAP_DTR 2'h1
`define PIQ_STRAP_TXRX 2'h2
`endif

/* File: src/piq_strap_sync.v */
// Three-stage synchroniser with agreement filter for strap pins
`include "piq_defs.vh"
`default_nettype none
module piq_strap_sync #(
  parameter W = 2
) (
  input wire clk_i,
  input wire rstn_i,
  input wire ce_i,
  input wire [W-1:0] pin_i,
  output reg [W-1:0] level_o
);
  reg [W-1:0] s1;
  reg [W-1:0] s2;
  reg [W-1:0] s3;
  // ===========================================================================
  // Capture
  // First stage is only read by the second to keep metastability contained
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1 <= {W{1'b0}};
      s2 <= {W{1'b0}};
      s3 <= {W{1'b0}};
      level_o <= {W{1'b0}};
    end else if (ce_i) begin
      s1 <= pin_i;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level_o <= s2;
      end
    end
  end
endmodule
`default_nettype wire

/* File: src/piq_port_info.v */
// Per-port interface info, interrupt enable and pending registers
`include "piq_defs.vh"
`default_nettype none
module piq_port_info #(
  parameter NPORT = 4
) (
  input wire clk_i,
  input wire rstn_i,
  input wire ce_i,
  input wire [5:0] addr_i,
  input wire rd_i,
  input wire wr_i,
  input wire [7:0] wdata_i,
  output reg [7:0] rdata_o,
  output reg rvalid_o,
  input wire [1:0] port1_line_type_strap_i,
  input wire [1:0] port2_line_type_strap_i,
  input wire [1:0] port3_line_type_strap_i,
  input wire [1:0] port4_line_type_strap_i,
  input wire [1:0] toggle_line_strap_i,
  input wire [NPORT-1:0] port_irq_i,
  output reg irq_o
);
  wire [1:0] t1;
  wire [1:0] t2;
  wire [1:0] t3;
  wire [1:0] t4;
  wire [1:0] tgl;
  wire [7:0] info1;
  wire [7:0] info2;
  wire [7:0] info3;
  wire [7:0] info4;
  wire [7:0] enable_view;
  wire [7:0] pending_view;
  wire enable_write;
  reg [NPORT-1:0] port_interrupt_enable;
  reg [NPORT-1:0] next_enable;
  reg [7:0] next_rdata;
  reg next_rvalid;
  reg next_irq;
  reg hit;

  // ===========================================================================
  // Strap synchronisers
  // Straps are static in practice but still synchronised; a flicker is filtered
  piq_strap_sync #(
    .W(2)
  ) u_s1 (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .pin_i(port1_line_type_strap_i),
    .level_o(t1)
  );

  piq_strap_sync #(
    .W(2)
  ) u_s2 (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .pin_i(port2_line_type_strap_i),
    .level_o(t2)
  );

  piq_strap_sync #(
    .W(2)
  ) u_s3 (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .pin_i(port3_line_type_strap_i),
    .level_o(t3)
  );

  piq_strap_sync #(
    .W(2)
  ) u_s4 (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .pin_i(port4_line_type_strap_i),
    .level_o(t4)
  );

  // ===========================================================================
  // Toggle strap
  // One strap serves all four ports; there are no per-port toggle pins
  piq_strap_sync #(
    .W(2)
  ) u_st (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .pin_i(toggle_line_strap_i),
    .level_o(tgl)
  );

  // ===========================================================================
  // Encoding helpers
  function [3:0] type_code;
    input [1:0] s;
    begin
      case (s)
        `PIQ_STRAP_RS422: type_code = `PIQ_TYPE_RS422;
        `PIQ_STRAP_RS485: type_code = `PIQ_TYPE_RS485;
        default: type_code = `PIQ_TYPE_RS232;
      endcase
    end
  endfunction

  // Strap code 11 is no documented selection; it falls back to RTS
  function [1:0] toggle_code;
    input [1:0] g;
    begin
      case (g)
        `PIQ_STRAP_DTR: toggle_code = `PIQ_TGL_DTR;
        `PIQ_STRAP_TXRX: toggle_code = `PIQ_TGL_TXRX;
        default: toggle_code = `PIQ_TGL_RTS;
      endcase
    end
  endfunction

  // RS232 leaves the toggle field meaningless; forced to zero for determinism
  function [7:0] info_byte;
    input [1:0] s;
    input [1:0] g;
    reg [3:0] ty;
    reg [1:0] tg;
    begin
      ty = type_code(s);
      tg = toggle_code(g);
      if (ty == `PIQ_TYPE_RS232) begin
        tg = `PIQ_TGL_RTS; // RL3
      end
      info_byte = {ty, tg, `PIQ_UNUSED_LOW}; // RL4
    end
  endfunction

  // ===========================================================================
  // Interface info bytes
  assign info1 = info_byte(t1, tgl); // RL1 RL2
  assign info2 = info_byte(t2, tgl); // RL5 RL8
  assign info3 = info_byte(t3, tgl); // RL6 RL8
  assign info4 = info_byte(t4, tgl); // RL7 RL8

  // ===========================================================================
  // Enable, pending and write qualifier
  assign enable_view = {`PIQ_ZERO_HIGH, port_interrupt_enable}; // RL9
  // Pending is a live view; clearing belongs to the port logic
  assign pending_view = {`PIQ_ZERO_HIGH, ~port_irq_i}; // RL10 RL11
  // Only the enable register takes writes
  assign enable_write = wr_i && addr_i == `PIQ_OFS_ENABLE;

  // ===========================================================================
  // Read decode
  always @* begin
    next_rdata = `PIQ_RDATA_IDLE;
    hit = 1'b1;
    case (addr_i)
      `PIQ_OFS_INFO1: next_rdata = info1; // RL1 RL2
      `PIQ_OFS_INFO2: next_rdata = info2; // RL5 RL8
      `PIQ_OFS_INFO3: next_rdata = info3; // RL6 RL8
      `PIQ_OFS_INFO4: next_rdata = info4; // RL7 RL8
      `PIQ_OFS_ENABLE: next_rdata = enable_view; // RL9
      `PIQ_OFS_PENDING: next_rdata = pending_view; // RL10 RL11
      default: hit = 1'b0;
    endcase
  end

  // ===========================================================================
  // Enable next state
  // Writes to any other offset, the info bytes included, are dropped
  always @* begin
    next_enable = port_interrupt_enable;
    if (enable_write) begin
      next_enable = wdata_i[NPORT-1:0]; // RL9
    end
  end

  // ===========================================================================
  // Response and interrupt next state
  always @* begin
    next_rvalid = rd_i;
    next_irq = |(port_irq_i & port_interrupt_enable); // RL12
  end

  // ===========================================================================
  // Interrupt enable register
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      port_interrupt_enable <= `PIQ_ENABLE_RESET;
    end else if (ce_i) begin
      port_interrupt_enable <= next_enable; // RL9
    end
  end

  // ===========================================================================
  // Read response
  // Unmapped reads return zero so a stale byte never looks valid
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rvalid_o <= 1'b0;
      rdata_o <= `PIQ_RDATA_IDLE;
    end else if (ce_i) begin
      rvalid_o <= next_rvalid;
      if (rd_i && hit) begin
        rdata_o <= next_rdata;
      end else begin
        rdata_o <= `PIQ_RDATA_IDLE;
      end
    end
  end

  // ===========================================================================
  // Host interrupt
  // Registered so the pin never glitches while port levels settle
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_o <= 1'b0;
    end else if (ce_i) begin
      irq_o <= next_irq; // RL12
    end
  end
endmodule
`default_nettype wire

/* File: tb/piq_host.sv */
// Host model issuing option space reads and writes
`default_nettype none
module piq_host (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output logic rd_o = 0,
  output logic wr_o = 0,
  output logic [5:0] addr_o = 0,
  output logic [7:0] wdata_o = 0
);
  timeunit 1ns;
  timeprecision 1ns;
  // Address inverted once released, so a stale decode cannot pass
  task acc(input logic [5:0] a, input logic [7:0] d, input logic w, output logic [7:0] q);
    @(posedge clk_i) #1 {addr_o, wdata_o, wr_o, rd_o} = {a, d, w, !w};
    // Taken at the next edge; read data stands for that one cycle only
    @(posedge clk_i) #1 q = rdata_i;
    {addr_o, wr_o, rd_o} = {~a, 2'h0};
  endtask
endmodule
`default_nettype wire

/* File: tb/piq_port_info_assertions.sv */
// Checker of the port info block
`default_nettype none
module piq_chk (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic rd_i,
  input wire logic rvalid_o,
  input wire logic irq_o,
  input wire logic [5:0] addr_i,
  input wire logic [7:0] rdata_o,
  input wire logic [3:0] port_irq_i
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  wire logic rq = ce_i && rd_i;
  wire logic inf = rq && addr_i[5:2] == 4'h2;
  a_rd_ack: assert property (rq |=> rvalid_o) else $error("no ack");
  a_no_ack: assert property (ce_i && !rd_i |=> !rvalid_o) else $error("ack");
  a_pend_low: assert property (rq && addr_i == 6'h10 |=> rdata_o == {4'h0, ~$past(port_irq_i)})
    else $error("pend");
  a_en_high: assert property (rq && addr_i == 6'h0c |=> rdata_o[7:4] == 4'h0) else $error("en");
  a_info_low: assert property (inf |=> rdata_o[1:0] == 2'h0) else $error("low");
  a_type_code: assert property (inf |=> rdata_o[7:4] < 4'h3) else $error("type");
  a_tgl_rs232: assert property (inf |=> rdata_o[7:4] != 4'h0 || rdata_o[3:2] == 2'h0) else $error("tgl");
  a_irq_cause: assert property (irq_o && $past(ce_i) |-> $past(port_irq_i) != 4'h0) else $error("irq");
  c_irq: cover property (irq_o);
  c_pend: cover property (rq && addr_i == 6'h10);
  c_rs485: cover property (inf ##1 rdata_o[7:4] == 4'h2);
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// Bench of the port info block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, rstn_i = 0, ce = 1, rd, wr, irq, rv;
  logic [5:0] ad;
  logic [7:0] wd, rdt, q;
  logic [1:0] s [4] = '{default: 0}, tg = 0;
  logic [3:0] pi = 0;
  int n_mismatch = 0, cmp_count = 0;
  always #5 clk_i = ~clk_i;
  piq_port_info piq_port_info_i (.clk_i, .rstn_i, .ce_i(ce), .addr_i(ad), .rd_i(rd), .wr_i(wr), .wdata_i(wd),
    .rdata_o(rdt), .rvalid_o(rv), .port1_line_type_strap_i(s[0]), .port2_line_type_strap_i(s[1]),
    .port3_line_type_strap_i(s[2]), .port4_line_type_strap_i(s[3]), .toggle_line_strap_i(tg), .port_irq_i(pi),
    .irq_o(irq));
  piq_host piq_host_i (.clk_i, .rdata_i(rdt), .rd_o(rd), .wr_o(wr), .addr_o(ad), .wdata_o(wd));
  task chk(input logic [7:0] g, e);
    cmp_count++;
    n_mismatch += int'(g !== e);
    if (g !== e) $display("Error %0t got %h exp %h", $time, g, e);
  endtask
  task chk_bit(input logic g, e);
    cmp_count++;
    n_mismatch += int'(g !== e);
    if (g !== e) $display("Error %0t got %h exp %h", $time, g, e);
  endtask
  task rdc(input logic [5:0] a, input logic [7:0] e);
    piq_host_i.acc(a, 8'h00, 1'b0, q);
    chk_bit(rv, 1'b1);
    chk(q, e);
  endtask
  task test_done(input int f);
    n_mismatch += f;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task t_info;
    for (int k = 0; k < 3; k++) begin
      tg = 2'(k);
      for (int n = 0; n < 4; n++) s[n] = 2'((k + n) % 3);
      repeat (6) @(posedge clk_i);
      for (int n = 0; n < 4; n++) begin
        rdc(6'h08 + 6'(n), {2'h0, s[n], |s[n] ? tg : 2'h0, 2'h0});
      end
    end
  endtask
  task t_irq;
    rdc(6'h0c, 8'h00);
    piq_host_i.acc(6'h0c, 8'hf5, 1'b1, q);
    rdc(6'h0c, 8'h05);
    for (int m = 0; m < 16; m++) begin
      pi = 4'(m);
      rdc(6'h10, {4'h0, ~pi});
      chk_bit(irq, |(pi & 4'h5));
    end
  endtask
  // Clock enable low: requests and interrupt changes are ignored
  task t_freeze;
    repeat (2) @(posedge clk_i);
    #1 ce = 1'b0;
    pi = 4'h0;
    piq_host_i.acc(6'h0c, 8'h0a, 1'b1, q);
    piq_host_i.acc(6'h0c, 8'h00, 1'b0, q);
    chk_bit(rv, 1'b0);
    chk(q, 8'h00);
    chk_bit(irq, 1'b1);
    ce = 1'b1;
    rdc(6'h0c, 8'h05);
    chk_bit(irq, 1'b0);
  endtask
  // Mid-run reset clears the enable register and the interrupt
  task t_reset;
    piq_host_i.acc(6'h0c, 8'h0f, 1'b1, q);
    pi = 4'h8;
    repeat (2) @(posedge clk_i);
    #1 chk_bit(irq, 1'b1);
    rstn_i = 1'b0;
    repeat (3) @(posedge clk_i);
    #1 chk_bit(irq, 1'b0);
    rstn_i = 1'b1;
    rdc(6'h0c, 8'h00);
    chk_bit(irq, 1'b0);
    pi = 4'h0;
  endtask
  // Strap code 11 reads as RS232 with RTS; info writes are dropped and unmapped reads return zero
  task t_odd;
    s = '{2'h3, 2'h1, 2'h2, 2'h3};
    tg = 2'h3;
    repeat (6) @(posedge clk_i);
    rdc(6'h08, 8'h00);
    rdc(6'h09, 8'h10);
    rdc(6'h0a, 8'h20);
    rdc(6'h0b, 8'h00);
    piq_host_i.acc(6'h08, 8'hff, 1'b1, q);
    rdc(6'h08, 8'h00);
    rdc(6'h11, 8'h00);
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    #1 rstn_i = 1;
    t_irq;
    t_freeze;
    t_reset;
    t_info;
    t_odd;
    test_done(0);
  end
  initial #5000 test_done(1);
endmodule
bind piq_port_info piq_chk piq_chk_i (.clk_i, .rstn_i, .ce_i, .rd_i, .addr_i, .rdata_o, .rvalid_o, .port_irq_i, .irq_o);
`default_nettype wire
